// ===== irs_ctrl.sv
`timescale 1ns/100ps
// How it works
// - low-voltage reset sets status bit 4; software writing zero clears it.
// - bit 2 is a software read/write enable for the clock-guard interrupt.
// - with the clock guard optioned off, bit 2 has no effect.
// - hardware sets bit 1 on backup clock; status read clears it once recovered.
// - with the clock guard optioned off, bit 1 reads zero.
// - watchdog reset sets bit 0; cleared by zero write or low-voltage reset.
// - flags 00 external, 01 watchdog, 1x low-voltage reset.
// - low-voltage flag survives later external and watchdog resets.
// - status at index 002Bh; unused bits zero; enable and detect reset to zero.
// - service pushes PC, X, A, condition codes, then sets mask and loads vector in the same cycle.
// - interrupt return pops the stack, clearing the mask bit.
// - after reset the mask bit is set.
// - maskable requests other than external low level wait latched while masked, serviced once clear.
// - fixed priority: reset, trap, then vector 0 up to 13.
// - vector map from FFFEh down, two bytes per vector number.
// - trap is taken regardless of the mask bit.
// - wait wakes on any request; halt on external; active halt adds clock.
// - external edge latched, cleared on entry to its routine.
// - enabled pins of a group are NANDed before detection.
// - peripheral requests need mask clear and enable set, else stay pending.
// - peripheral clears drop the flag, and with it any pending request.
// - in halt the status register freezes and the clock guard stops.
module irs_ctrl (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire irs_pkg::irs_cpu_t cpu_i,
    input wire irs_pkg::irs_mode_t mode_i,
    input wire irs_pkg::irs_clk_t clk_i,
    input wire logic timebase_irq,
    input wire logic [15:0] ext_pins,
    input wire logic [15:0] ext_pin_en,
    input wire logic [irs_pkg::NUM_PERIPH-1:0] periph_flag,
    input wire logic [irs_pkg::NUM_PERIPH-1:0] periph_en,
    output irs_pkg::irs_seq_t seq_o,
    output logic wake_o,
    output logic guard_run_o
);
    typedef enum logic [2:0] {
        S_RSTVEC,
        S_RUN,
        S_PUSH,
        S_VEC,
        S_POP
    } irs_state_t;

    irs_state_t state_reg;
    irs_state_t state_next;
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;

    logic [7:0] idx;
    logic acc;
    logic rd_status;
    logic wr_status;
    logic wr_sense;
    logic frozen;

    logic lowv_flag_reg;
    logic wdog_flag_reg;
    logic ie_reg;
    logic detect_reg;
    logic push_reg;
    logic pop_reg;
    logic load_reg;
    logic mask_reg;
    logic [15:0] vec_reg;
    logic [7:0] status_val;
    logic [7:0] sense_reg;
    logic [31:0] rd_mux;

    logic [irs_pkg::NUM_EXT-1:0] ext_req;
    logic [irs_pkg::NUM_EXT-1:0] ext_ack;
    logic guard_req;
    logic [irs_pkg::NUM_VEC-1:0] req;
    logic [3:0] sel_vec;
    logic found;
    logic trap_pend_reg;
    logic cur_trap_reg;
    logic [3:0] cur_vec_reg;
    logic take;
    logic take_trap;
    logic [3:0] vec_off;

    // ---------------- wishbone slave ----------------
    assign idx = wb_adr_i[9:2];
    assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign frozen = (mode_i == irs_pkg::IRS_HALT);
    assign rd_status = acc && !wb_we_i && idx == irs_pkg::IDX_STATUS;
    assign wr_status = acc && wb_we_i && wb_sel_i[0] && idx == irs_pkg::IDX_STATUS && !frozen;
    assign wr_sense = acc && wb_we_i && wb_sel_i[0] && idx == irs_pkg::IDX_EXT_SENSE;

    always_comb begin
        status_val = 8'h00;
        status_val[irs_pkg::BIT_LOWV] = lowv_flag_reg;
        status_val[irs_pkg::BIT_IE] = ie_reg;
        status_val[irs_pkg::BIT_DET] = detect_reg & clk_i.guard_opt;
        status_val[irs_pkg::BIT_WDOG] = wdog_flag_reg;
    end

    always_comb begin
        case (idx)
            irs_pkg::IDX_STATUS: rd_mux = 32'(status_val);
            irs_pkg::IDX_EXT_SENSE: rd_mux = 32'(sense_reg);
            irs_pkg::IDX_PENDING: rd_mux = 32'(req);
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // unmapped addresses still ack, reading zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= acc;
            wb_dat_o <= (acc && !wb_we_i) ? rd_mux : 32'h0000_0000;
        end
    end

    // ---------------- reset-cause flags ----------------
    // no reset: these must survive the resets they record
    always_ff @(posedge clk) begin
        if (clk_i.lowv_reset) begin
            lowv_flag_reg <= 1'b1;
        end else if (wr_status && !wb_dat_i[irs_pkg::BIT_LOWV]) begin
            lowv_flag_reg <= 1'b0;
        end
    end
    // external and watchdog resets never touch it

    always_ff @(posedge clk) begin
        if (clk_i.lowv_reset) begin
            wdog_flag_reg <= 1'b0;
        end else if (clk_i.wdg_reset) begin
            wdog_flag_reg <= 1'b1;
        end else if (wr_status && !wb_dat_i[irs_pkg::BIT_WDOG]) begin
            wdog_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ie_reg <= 1'b0;
        end else if (wr_status) begin
            ie_reg <= wb_dat_i[irs_pkg::BIT_IE];
        end
    end

    // detection set wins over the read clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            detect_reg <= 1'b0;
        end else if (!clk_i.guard_opt) begin
            detect_reg <= 1'b0;
        end else if (frozen) begin
            detect_reg <= detect_reg;
        end else if (clk_i.safe_osc_sel) begin
            detect_reg <= 1'b1;
        end else if (rd_status) begin
            detect_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            guard_run_o <= 1'b0;
        end else begin
            guard_run_o <= clk_i.guard_opt && !frozen;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sense_reg <= irs_pkg::EXT_SENSE_RST;
        end else if (wr_sense) begin
            sense_reg <= wb_dat_i[7:0];
        end
    end

    // ---------------- request collection ----------------
    genvar g;
    generate
        for (g = 0; g < irs_pkg::NUM_EXT; g++) begin : gen_ext
            assign ext_ack[g] = state_reg == S_VEC && !cur_trap_reg &&
                cur_vec_reg == irs_pkg::VEC_EXT0 + 4'(g);
            irs_ext_detect u_det (
                .clk(clk),
                .rst_b(rst_b),
                .pins(ext_pins[g*irs_pkg::PINS_PER_GRP +: irs_pkg::PINS_PER_GRP]),
                .pin_en(ext_pin_en[g*irs_pkg::PINS_PER_GRP +: irs_pkg::PINS_PER_GRP]),
                .sense(irs_pkg::irs_sense_t'(sense_reg[2*g +: 2])),
                .ack(ext_ack[g]),
                .req(ext_req[g])
            );
        end
    endgenerate

    assign guard_req = detect_reg & ie_reg & clk_i.guard_opt;

    always_comb begin
        req = '0;
        req[irs_pkg::VEC_GUARD] = timebase_irq | guard_req;
        for (int i = 0; i < irs_pkg::NUM_EXT; i++) begin
            req[int'(irs_pkg::VEC_EXT0) + i] = ext_req[i];
        end
        for (int i = 0; i < irs_pkg::NUM_PERIPH; i++) begin
            // flag level is the pending latch; clearing it drops it
            req[int'(irs_pkg::VEC_PERIPH0) + i] = periph_flag[i] & periph_en[i];
        end
    end

    // lowest vector number wins
    always_comb begin
        sel_vec = irs_pkg::VEC_LAST;
        found = 1'b0;
        for (int n = irs_pkg::NUM_VEC - 1; n >= 0; n--) begin
            if (req[n]) begin
                sel_vec = 4'(n);
                found = 1'b1;
            end
        end
    end

    // ---------------- service sequencer ----------------
    assign take_trap = trap_pend_reg;
    assign take = state_reg == S_RUN && cpu_i.instr_end &&
        (take_trap || (found && !seq_o.i_bit));
    assign vec_off = irs_pkg::VEC_LAST - sel_vec;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            S_RSTVEC: begin
                state_next = S_VEC;
            end
            S_RUN: begin
                cnt_next = 3'h0;
                if (take) begin
                    state_next = S_PUSH;
                end else if (cpu_i.ret_exec) begin
                    state_next = S_POP;
                end
            end
            S_PUSH: begin
                cnt_next = cnt_reg + 3'h1;
                if (cnt_reg == 3'(irs_pkg::STACK_BYTES - 1)) begin
                    state_next = S_VEC;
                end
            end
            S_VEC: begin
                state_next = S_RUN;
            end
            S_POP: begin
                cnt_next = cnt_reg + 3'h1;
                if (cnt_reg == 3'(irs_pkg::STACK_BYTES - 1)) begin
                    state_next = S_RUN;
                end
            end
            default: begin
                state_next = S_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= S_RSTVEC;
            cnt_reg <= 3'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // strobes follow the next state so they leave flops aligned with it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            push_reg <= 1'b0;
            pop_reg <= 1'b0;
            load_reg <= 1'b0;
        end else begin
            push_reg <= state_next == S_PUSH;
            pop_reg <= state_next == S_POP;
            load_reg <= state_next == S_VEC;
        end
    end

    // one driver for the whole struct, every field a flop
    assign seq_o = {push_reg, pop_reg, load_reg, vec_reg, mask_reg};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vec_reg <= irs_pkg::VEC_RESET;
            cur_trap_reg <= 1'b0;
            cur_vec_reg <= 4'h0;
        end else if (take) begin
            cur_trap_reg <= take_trap;
            cur_vec_reg <= sel_vec;
            if (take_trap) begin
                vec_reg <= irs_pkg::VEC_TRAP;
            end else begin
                vec_reg <= irs_pkg::VEC_BASE + {11'h000, vec_off, 1'b0};
            end
        end
    end

    // a trap issued at the very edge it is taken is kept
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            trap_pend_reg <= 1'b0;
        end else if (cpu_i.trap_exec) begin
            trap_pend_reg <= 1'b1;
        end else if (take && take_trap) begin
            trap_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_reg <= 1'b1;
        end else if (state_next == S_VEC) begin
            mask_reg <= 1'b1;
        end else if (state_reg == S_POP && state_next == S_RUN) begin
            mask_reg <= 1'b0;
        end else if (cpu_i.lp_entry || cpu_i.clr_i) begin
            mask_reg <= 1'b0;
        end else if (cpu_i.set_i) begin
            mask_reg <= 1'b1;
        end
    end

    // ---------------- wake-up ----------------
    // peripheral clocks are stopped in both halts, so only these wake
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_o <= 1'b0;
        end else begin
            case (mode_i)
                irs_pkg::IRS_WAIT: wake_o <= |req || trap_pend_reg;
                irs_pkg::IRS_HALT: wake_o <= |ext_req;
                irs_pkg::IRS_AHALT: wake_o <= |ext_req || req[irs_pkg::VEC_GUARD];
                default: wake_o <= 1'b0;
            endcase
        end
    end

    // ---------------- assertions ----------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence push_burst;
        seq_o.stack_push [*5] ##1 (seq_o.load_pc && seq_o.i_bit);
    endsequence

    sequence pop_burst;
        seq_o.stack_pop [*5] ##1 !seq_o.i_bit;
    endsequence

    mask_after_reset_a: assert property (
        state_reg == S_RSTVEC |-> seq_o.i_bit)
        else $error("mask bit not set after reset");

    service_entry_a: assert property (
        take |=> push_burst)
        else $error("service entry sequence wrong");

    return_restore_a: assert property (
        state_reg == S_RUN && !take && cpu_i.ret_exec |=> pop_burst)
        else $error("return sequence wrong");

    trap_unmasked_a: assert property (
        state_reg == S_RUN && cpu_i.instr_end && trap_pend_reg |=>
        seq_o.stack_push ##5 seq_o.vec_addr == irs_pkg::VEC_TRAP)
        else $error("trap not taken");

    masked_hold_a: assert property (
        state_reg == S_RUN && seq_o.i_bit && !trap_pend_reg |=> !seq_o.stack_push)
        else $error("masked request serviced");

    guard_forced_zero_a: assert property (
        acc && !wb_we_i && idx == irs_pkg::IDX_STATUS && !clk_i.guard_opt
        |=> !wb_dat_o[irs_pkg::BIT_DET])
        else $error("detect bit visible with guard off");

    lowv_flag_set_a: assert property (
        clk_i.lowv_reset |=> lowv_flag_reg && !wdog_flag_reg)
        else $error("low-voltage reset not recorded");

    wdg_flag_set_a: assert property (
        clk_i.wdg_reset && !clk_i.lowv_reset |=> wdog_flag_reg && $stable(lowv_flag_reg))
        else $error("watchdog reset not recorded");

    guard_gate_a: assert property (
        !clk_i.guard_opt && !timebase_irq |-> !req[irs_pkg::VEC_GUARD])
        else $error("guard request with guard optioned off");

    halt_frozen_a: assert property (
        frozen && !clk_i.lowv_reset && !clk_i.wdg_reset |=>
        $stable(ie_reg) && !guard_run_o)
        else $error("status changed in halt");

endmodule

// ===== irs_pkg.sv
package irs_pkg;

    localparam int NUM_VEC = 14;
    localparam int NUM_EXT = 4;
    localparam int NUM_PERIPH = 5;
    localparam int PINS_PER_GRP = 4;
    localparam int STACK_BYTES = 5;

    // word indices on the bus; byte address is four times the index
    localparam logic [7:0] IDX_STATUS = 8'h2b;
    localparam logic [7:0] IDX_EXT_SENSE = 8'h2c;
    localparam logic [7:0] IDX_PENDING = 8'h2d;

    localparam int BIT_WDOG = 0;
    localparam int BIT_DET = 1;
    localparam int BIT_IE = 2;
    localparam int BIT_LOWV = 4;

    localparam logic [7:0] EXT_SENSE_RST = 8'h00;

    localparam logic [3:0] VEC_GUARD = 4'h1;
    localparam logic [3:0] VEC_EXT0 = 4'h2;
    localparam logic [3:0] VEC_PERIPH0 = 4'h7;
    localparam logic [3:0] VEC_LAST = 4'hd;

    localparam logic [15:0] VEC_RESET = 16'hfffe;
    localparam logic [15:0] VEC_TRAP = 16'hfffc;
    localparam logic [15:0] VEC_BASE = 16'hffe0;

    typedef enum logic [1:0] {
        IRS_FALL_LOW,
        IRS_RISE,
        IRS_FALL,
        IRS_BOTH
    } irs_sense_t;

    typedef enum logic [1:0] {
        IRS_RUN,
        IRS_WAIT,
        IRS_HALT,
        IRS_AHALT
    } irs_mode_t;

    typedef struct packed {
        logic instr_end;
        logic trap_exec;
        logic ret_exec;
        logic lp_entry;
        logic set_i;
        logic clr_i;
    } irs_cpu_t;

    typedef struct packed {
        logic stack_push;
        logic stack_pop;
        logic load_pc;
        logic [15:0] vec_addr;
        logic i_bit;
    } irs_seq_t;

    typedef struct packed {
        logic lowv_reset;
        logic wdg_reset;
        logic guard_opt;
        logic safe_osc_sel;
    } irs_clk_t;

endpackage

// ===== irs_ext_detect.sv
`timescale 1ns/100ps
module irs_ext_detect (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [irs_pkg::PINS_PER_GRP-1:0] pins,
    input wire logic [irs_pkg::PINS_PER_GRP-1:0] pin_en,
    input wire irs_pkg::irs_sense_t sense,
    input wire logic ack,
    output logic req
);
    logic nand_src;
    logic prev_reg;
    logic edge_reg;
    logic hit;
    logic any_en;

    // disabled pins are forced high so they never mask the group
    assign nand_src = ~&(pins | ~pin_en);
    assign any_en = |pin_en;

    always_comb begin
        case (sense)
            irs_pkg::IRS_FALL_LOW: hit = prev_reg & ~nand_src;
            irs_pkg::IRS_RISE: hit = nand_src & ~prev_reg;
            irs_pkg::IRS_FALL: hit = prev_reg & ~nand_src;
            irs_pkg::IRS_BOTH: hit = nand_src ^ prev_reg;
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= nand_src;
        end
    end

    // set wins over the automatic clear on vector entry
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            edge_reg <= 1'b0;
        end else if (hit && any_en) begin
            edge_reg <= 1'b1;
        end else if (ack) begin
            edge_reg <= 1'b0;
        end
    end

    // low level is not latched: it requests only while it lasts
    assign req = edge_reg |
        (sense == irs_pkg::IRS_FALL_LOW && any_en && !nand_src);

endmodule

// ===== irs_cpu_model.sv
`timescale 1ns/100ps
module irs_cpu_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire irs_pkg::irs_seq_t seq,
    input wire logic [4:0] op,
    output irs_pkg::irs_cpu_t cpu,
    output logic [15:0] last_vec,
    output logic [7:0] takes,
    output logic [3:0] push_len,
    output logic [3:0] pop_len
);
    logic [1:0] phase_reg;
    logic [3:0] push_reg;
    logic [3:0] pop_reg;
    // no instruction ends while the stack is busy, as a real core is stalled then
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_reg <= 2'h0;
            cpu <= '0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
            cpu.instr_end <= phase_reg == 2'h3 && !seq.stack_push && !seq.stack_pop;
            {cpu.clr_i, cpu.set_i, cpu.lp_entry, cpu.ret_exec, cpu.trap_exec} <= op;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            push_reg <= 4'h0;
            push_len <= 4'h0;
            pop_reg <= 4'h0;
            pop_len <= 4'h0;
            takes <= 8'h00;
            last_vec <= 16'h0000;
        end else if (seq.load_pc) begin
            push_len <= push_reg;
            push_reg <= 4'h0;
            takes <= takes + 8'h01;
            last_vec <= seq.vec_addr;
        end else if (seq.stack_push) begin
            push_reg <= push_reg + 4'h1;
        end else if (seq.stack_pop) begin
            pop_reg <= pop_reg + 4'h1;
        end else if (pop_reg != 4'h0) begin
            pop_len <= pop_reg;
            pop_reg <= 4'h0;
        end
    end
endmodule

// ===== tb_interrupt_and_reset_status.sv
`timescale 1ns/100ps
module tb_interrupt_and_reset_status;
    logic clk, rst_b, cyc, stb, we, ack, tb_irq, wake, grun;
    logic [9:0] adr;
    logic [31:0] wdat, rdat, seed;
    logic [15:0] pins, pen, last_vec, rd;
    logic [4:0] pf, pe, op;
    logic [7:0] takes;
    logic [3:0] push_len, pop_len, sel;
    irs_pkg::irs_cpu_t cpu;
    irs_pkg::irs_mode_t mode;
    irs_pkg::irs_clk_t cin;
    irs_pkg::irs_seq_t seq;
    int num_errors = 0, samples_checked = 0, k, p;
    irs_ctrl dut_u (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .cpu_i(cpu), .mode_i(mode), .clk_i(cin), .timebase_irq(tb_irq), .ext_pins(pins),
        .ext_pin_en(pen), .periph_flag(pf), .periph_en(pe), .seq_o(seq), .wake_o(wake),
        .guard_run_o(grun));
    irs_cpu_model cpu_u (.clk(clk), .rst_b(rst_b), .seq(seq), .op(op), .cpu(cpu),
        .last_vec(last_vec), .takes(takes), .push_len(push_len), .pop_len(pop_len));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // two bytes per vector number, counting down from the top
    function automatic logic [15:0] vec_of(input int n);
        return 16'hffe0 + 16'(2 * (13 - n));
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h1;
        adr <= {idx, 2'b00};
        wdat <= {24'h000000, wd};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        rd = rdat[15:0];
        chk("bus ack", 16'h0001, {15'h0000, ack});
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rchk(input string what, input logic [7:0] idx, input logic [15:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(what, exp, rd);
    endtask
    // op bits: trap, return, low power entry, set mask, clear mask
    task automatic op_p(input logic [4:0] m);
        @(posedge clk);
        op <= m;
        @(posedge clk);
        op <= 5'h00;
    endtask
    task automatic take(input string what, input logic [15:0] exp);
        logic [7:0] t0 = takes;
        int n = 0;
        while (takes === t0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk(what, exp, last_vec);
        chk("push length", 16'h0005, {12'h000, push_len});
        chk("mask in service", 16'h0001, {15'h0000, seq.i_bit});
    endtask
    task automatic ret();
        int n = 0;
        op_p(5'h02);
        while (seq.i_bit !== 1'b0 && n < 60) begin
            @(posedge clk);
            n++;
        end
        chk("mask after return", 16'h0000, {15'h0000, seq.i_bit});
        @(posedge clk);
        chk("pop length", 16'h0005, {12'h000, pop_len});
    endtask
    task automatic idle(input string what, input int n);
        logic [7:0] t0 = takes;
        repeat (n) @(posedge clk);
        chk(what, {8'h00, t0}, {8'h00, takes});
    endtask
    task automatic rst_ev(input logic l, input logic w);
        @(posedge clk);
        cin.lowv_reset <= l;
        cin.wdg_reset <= w;
        @(posedge clk);
        cin.lowv_reset <= 1'b0;
        cin.wdg_reset <= 1'b0;
    endtask
    task automatic wk(input irs_pkg::irs_mode_t m, input logic exp, input string what);
        @(posedge clk);
        mode <= m;
        repeat (3) @(posedge clk);
        chk(what, {15'h0000, exp}, {15'h0000, wake});
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // whole run needs under a thousand cycles
    initial begin
        repeat (12000) @(posedge clk);
        num_errors++;
        complete_run();
    end
    initial begin
        {rst_b, cyc, stb, we, tb_irq} = 5'h00;
        {adr, wdat, pins, pen, pf, pe, op, sel} = '0;
        cin = '0;
        mode = irs_pkg::IRS_RUN;
        seed = 32'ha5254509;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        chk("reset vector", 16'hfffe, last_vec);
        chk("mask after reset", 16'h0001, {15'h0000, seq.i_bit});
        // cause flags power up unknown, so define them first
        bus(1'b1, 8'h2b, 8'h00);
        rchk("status cleared", 8'h2b, 16'h0000);
        rchk("unmapped read", 8'h3f, 16'h0000);
        $display("test reset done");
        rst_ev(1'b1, 1'b0);
        rchk("low volt flag", 8'h2b, 16'h0010);
        rst_ev(1'b0, 1'b1);
        rchk("low volt kept", 8'h2b, 16'h0011);
        bus(1'b1, 8'h2b, 8'h00);
        rchk("flags cleared", 8'h2b, 16'h0000);
        rst_ev(1'b0, 1'b1);
        rchk("watchdog cause", 8'h2b, 16'h0001);
        rst_ev(1'b1, 1'b0);
        rchk("watchdog dropped", 8'h2b, 16'h0010);
        bus(1'b1, 8'h2b, 8'h00);
        $display("test flags done");
        for (k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            bus(1'b1, 8'h2b, seed[7:0] | 8'h13);
            rchk("enable readback", 8'h2b, {8'h00, seed[7:0] & 8'h04});
        end
        bus(1'b1, 8'h2b, 8'h04);
        @(posedge clk) cin.safe_osc_sel <= 1'b1;
        rchk("detect forced off", 8'h2b, 16'h0004);
        rchk("no guard pending", 8'h2d, 16'h0000);
        @(posedge clk) cin.guard_opt <= 1'b1;
        rchk("detect set", 8'h2b, 16'h0006);
        rchk("guard pending", 8'h2d, 16'h0002);
        chk("guard runs", 16'h0001, {15'h0000, grun});
        @(posedge clk) cin.safe_osc_sel <= 1'b0;
        rchk("detect held", 8'h2b, 16'h0006);
        rchk("detect read clear", 8'h2b, 16'h0004);
        op_p(5'h10);
        @(posedge clk) cin.safe_osc_sel <= 1'b1;
        take("guard vector", vec_of(1));
        @(posedge clk) cin.safe_osc_sel <= 1'b0;
        rchk("routine sees guard", 8'h2b, 16'h0006);
        ret();
        idle("guard served once", 20);
        @(posedge clk) tb_irq <= 1'b1;
        take("timebase vector", vec_of(1));
        rchk("routine sees timebase", 8'h2b, 16'h0004);
        tb_irq <= 1'b0;
        ret();
        @(posedge clk) cin.guard_opt <= 1'b0;
        cin.safe_osc_sel <= 1'b1;
        idle("guard optioned off", 40);
        cin.safe_osc_sel <= 1'b0;
        $display("test guard done");
        seed = lfsr(seed);
        for (k = 0; k < 5; k++) begin
            p = (k + int'(seed[2:0])) % 5;
            @(posedge clk) pf[p] <= 1'b1;
            idle("disabled peripheral", 20);
            op_p(5'h08);
            // mask lands one edge after the strobe
            @(posedge clk) pe[p] <= 1'b1;
            idle("masked peripheral", 20);
            op_p(5'h10);
            take("peripheral vector", vec_of(7 + p));
            pf <= 5'h00;
            pe <= 5'h00;
            ret();
        end
        $display("test peripherals done");
        op_p(5'h08);
        @(posedge clk) pf[4] <= 1'b1;
        pe[4] <= 1'b1;
        tb_irq <= 1'b1;
        op_p(5'h01);
        take("trap while masked", 16'hfffc);
        ret();
        take("timebase first", vec_of(1));
        tb_irq <= 1'b0;
        ret();
        take("eeprom last", vec_of(11));
        pf <= 5'h00;
        pe <= 5'h00;
        ret();
        $display("test priority done");
        // groups alternate falling edge and falling edge with low level
        bus(1'b1, 8'h2c, 8'h22);
        rchk("sense readback", 8'h2c, 16'h0022);
        for (k = 0; k < 4; k++) begin
            op_p(5'h08);
            pen <= 16'h0003 << (4 * k);
            pins <= 16'h0001 << (4 * k);
            rchk("low pin holds group", 8'h2d, 16'h0000);
            @(posedge clk) pins <= 16'h0003 << (4 * k);
            @(posedge clk) pins <= 16'h0000;
            rchk("edge latched", 8'h2d, 16'h0004 << k);
            op_p(5'h10);
            take("external vector", vec_of(2 + k));
            rchk("latch cleared", 8'h2d, 16'h0000);
            pen <= 16'h0000;
            ret();
        end
        $display("test external done");
        cin.guard_opt <= 1'b1;
        op_p(5'h04);
        pf <= 5'h01;
        pe <= 5'h01;
        wk(irs_pkg::IRS_WAIT, 1'b1, "wait wake");
        wk(irs_pkg::IRS_HALT, 1'b0, "halt peripheral");
        chk("guard stopped", 16'h0000, {15'h0000, grun});
        bus(1'b1, 8'h2b, 8'h00);
        rchk("status frozen", 8'h2b, 16'h0004);
        pf <= 5'h00;
        tb_irq <= 1'b1;
        wk(irs_pkg::IRS_HALT, 1'b0, "halt timebase");
        wk(irs_pkg::IRS_AHALT, 1'b1, "active halt timebase");
        tb_irq <= 1'b0;
        // group zero on rising edge: enabling a low pin raises it
        bus(1'b1, 8'h2c, 8'h01);
        pen <= 16'h0001;
        wk(irs_pkg::IRS_HALT, 1'b1, "halt external");
        op_p(5'h08);
        mode <= irs_pkg::IRS_RUN;
        $display("test wake done");
        complete_run();
    end
endmodule
